// file: ssdc_params.svh
// constants for the scan switch-delay controller
// assumes inclusion by every design file that needs offsets or timing
`ifndef SSDC_PARAMS_SVH
`define SSDC_PARAMS_SVH

// ==========================================
// register offsets
`define SSDC_OFS_MAIN_CONFIG   3'h0
`define SSDC_OFS_TIMING        3'h1
`define SSDC_OFS_CHAN_MASK     3'h2
`define SSDC_OFS_COMMAND       3'h3
`define SSDC_OFS_STATUS        3'h4
`define SSDC_OFS_RESULT_COUNT  3'h5

// ==========================================
// field positions
`define SSDC_BIT_BYPASS        0
`define SSDC_BIT_CHOP          1
`define SSDC_BIT_BIAS_EN       2
`define SSDC_BIT_BIAS_HIGH     3
`define SSDC_BIT_AUTO_SCAN     4
`define SSDC_BIT_RUN           5
`define SSDC_BIT_PULSE_CMD     0

// ==========================================
// reset values
`define SSDC_RST_MAIN_CONFIG   8'h10
`define SSDC_RST_TIMING        8'h30
`define SSDC_RST_CHAN_MASK     8'hff

// ==========================================
// timing counts, in system clocks
`define SSDC_UNIT_CLKS         128
// 128 x 4.265625 = 128 x 273 / 64
`define SSDC_OVERHEAD_CLKS     ((`SSDC_UNIT_CLKS * 273) / 64)

`endif

// file: ssdc_pkg.sv
// types shared by the scan switch-delay controller
// assumes nothing beyond a SystemVerilog compiler
package ssdc_pkg;

    typedef enum logic [2:0] {
        SSDC_IDLE    = 3'b000,
        SSDC_SWITCH  = 3'b001,
        SSDC_SETTLE  = 3'b010,
        SSDC_CONVERT = 3'b011,
        SSDC_DONE    = 3'b100
    } ssdc_state_type;

endpackage : ssdc_pkg

// file: ssdc_sync.sv
// three-stage synchroniser for one pin input
// assumes the input is asynchronous to clk; rst_n is already synchronised
`timescale 1ns/1ps

module ssdc_sync (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // pin and filtered level
    input  wire logic pin,
    output logic      level
);

    logic s1;
    logic s2;
    logic s3;

    // ==========================================
    // stages
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // a change counts only once stages two and three agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level <= 1'b0;
        end else if (s2 == s3) begin
            level <= s3;
        end
    end

endmodule : ssdc_sync

// file: ssdc_unit_timer.sv
// delay-unit divider: one-cycle tick every unit of system clocks
// assumes clr restarts the unit from zero in the same cycle
`timescale 1ns/1ps
`include "ssdc_params.svh"

module ssdc_unit_timer (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // control and tick
    input  wire logic clr,
    output logic      tick
);

    localparam logic [6:0] LAST = 7'(`SSDC_UNIT_CLKS - 1);

    logic [6:0] cnt;

    // ==========================================
    // divider
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt  <= 7'h00;
            tick <= 1'b0;
        end else if (clr) begin
            cnt  <= 7'h00;
            tick <= 1'b0;
        end else begin
            tick <= (cnt == LAST);
            cnt  <= (cnt == LAST) ? 7'h00 : cnt + 7'h01;
        end
    end

endmodule : ssdc_unit_timer

// file: ssdc_scan_ctrl.sv
// conversion sequencer: channel scan, switch delay, chop, pulse mode,
// loop bypass and sensor-bias routing, with a small register port
// assumes a single 100 MHz clk; start_pin is asynchronous
`timescale 1ns/1ps
`include "ssdc_params.svh"

// Summary of operation
// [RULE1] auto scan waits the programmed settling delay after each channel switch
// [RULE2] delay select codes give 0,1,2,4,8,16,32,48 units
// [RULE3] one delay unit is 128 system clocks
// [RULE4] nonzero delay lengthens every per-channel conversion cycle
// [RULE5] chopping halves the result rate by converting twice per channel
// [RULE6] pulse mode converts exactly one channel per start rise or command; the code ignores any that arrive outside SSDC_IDLE
// [RULE7] host may pace pulses; internal delay still settles the reversed chop phase
// [RULE8] bypass bit zero connects mux output internally, else external loop pins
// [RULE9] multiplexer output pins stay driven whatever the bypass setting
// [RULE10] bias sources into selected positive, sinks from selected negative, two magnitudes
// [RULE11] bias reaches only the currently selected channel
// [RULE12] one result takes 128*(4^(3-rate)+4.265625+delay) clocks, doubled with chop
// [RULE13] rate select sets averages: 11->1, 10->4, 01->16, 00->64
// [RULE14] delay counter restarts each switch; conversion starts at programmed count
module ssdc_scan_ctrl (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // register port
    input  wire logic [2:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // conversion control pin
    input  wire logic        start_pin,
    // multiplexer and loop
    output logic      [3:0]  mux_pos_sel,
    output logic      [3:0]  mux_neg_sel,
    output logic             mux_out_en,
    output logic             loop_internal,
    output logic             chop_reverse,
    // sensor bias
    output logic      [15:0] bias_src_en,
    output logic      [15:0] bias_sink_en,
    output logic             bias_high,
    // converter handshake
    output logic             conv_start,
    output logic      [6:0]  conv_avg,
    output logic             data_ready
);

    // ==========================================
    // reset release
    logic rst_a;
    logic rst_n;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_a <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_a <= 1'b1;
            rst_n <= rst_a;
        end
    end

    // ==========================================
    // functions
    function automatic logic [5:0] delay_units(input logic [2:0] sel);
        unique case (sel)
            3'h0: delay_units = 6'd0;
            3'h1: delay_units = 6'd1;
            3'h2: delay_units = 6'd2;
            3'h3: delay_units = 6'd4;
            3'h4: delay_units = 6'd8;
            3'h5: delay_units = 6'd16;
            3'h6: delay_units = 6'd32;
            3'h7: delay_units = 6'd48;
        endcase
    endfunction : delay_units

    function automatic logic [6:0] avg_count(input logic [1:0] sel);
        unique case (sel)
            2'h3: avg_count = 7'd1;
            2'h2: avg_count = 7'd4;
            2'h1: avg_count = 7'd16;
            2'h0: avg_count = 7'd64;
        endcase
    endfunction : avg_count

    // next enabled pair after cur, wrapping; cur itself if it is the only one
    function automatic logic [2:0] next_pair(input logic [2:0] cur,
                                             input logic [7:0] mask);
        logic [2:0] cand;
        logic       found;
        cand      = cur;
        found     = 1'b0;
        next_pair = cur;
        for (int i = 1; i <= 8; i++) begin
            cand = 3'(cur + 3'(i));
            if (!found && mask[cand]) begin
                next_pair = cand;
                found     = 1'b1;
            end
        end
    endfunction : next_pair

    // ==========================================
    // registers
    logic [7:0] main_config_reg;
    logic [7:0] timing_reg;
    logic [7:0] chan_mask;
    logic [7:0] result_count;
    logic       pulse_cmd;

    logic [2:0] switch_delay_sel;
    logic [1:0] rate_sel;
    logic       cfg_chop;
    logic       cfg_auto;

    assign switch_delay_sel = timing_reg[2:0];
    assign rate_sel         = timing_reg[5:4];
    assign cfg_chop         = main_config_reg[`SSDC_BIT_CHOP];
    assign cfg_auto         = main_config_reg[`SSDC_BIT_AUTO_SCAN];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            main_config_reg <= `SSDC_RST_MAIN_CONFIG;
            timing_reg      <= `SSDC_RST_TIMING;
            chan_mask       <= `SSDC_RST_CHAN_MASK;
        end else if (reg_wr) begin
            if (reg_addr == `SSDC_OFS_MAIN_CONFIG) main_config_reg <= reg_wdata & 8'h3f;
            if (reg_addr == `SSDC_OFS_TIMING)      timing_reg      <= reg_wdata & 8'h37;
            if (reg_addr == `SSDC_OFS_CHAN_MASK)   chan_mask       <= reg_wdata;
        end
    end

    // command write is a one-cycle pulse, not stored
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_cmd <= 1'b0;
        end else begin
            pulse_cmd <= reg_wr && (reg_addr == `SSDC_OFS_COMMAND)
                         && reg_wdata[`SSDC_BIT_PULSE_CMD];
        end
    end

    // ==========================================
    // start pin
    logic start_level;
    logic start_prev;
    logic start_rise;

    ssdc_sync u_start_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .pin   (start_pin),
        .level (start_level)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            start_prev <= 1'b0;
        end else begin
            start_prev <= start_level;
        end
    end

    assign start_rise = start_level && !start_prev;

    // ==========================================
    // sequencer
    ssdc_pkg::ssdc_state_type state;
    ssdc_pkg::ssdc_state_type next_state;

    logic        run_level;
    logic        pulse_evt;
    logic        timer_clr;
    logic        unit_tick;
    logic [5:0]  unit_cnt;
    logic [13:0] conv_cnt;
    logic [13:0] conv_last;
    logic [2:0]  pair;
    logic        phase;
    logic        settled;
    logic        conv_end;

    assign run_level = start_level || main_config_reg[`SSDC_BIT_RUN];
    assign pulse_evt = start_rise || pulse_cmd;
    assign settled   = (unit_cnt == delay_units(switch_delay_sel));         // [RULE2] [RULE14]
    // overhead plus 128 clocks per first-stage output averaged
    assign conv_last = 14'(`SSDC_OVERHEAD_CLKS
                       + `SSDC_UNIT_CLKS * avg_count(rate_sel) - 1);      // [RULE12] [RULE13]
    assign conv_end  = (conv_cnt == conv_last);
    // restart the unit timer whenever a settle interval begins
    assign timer_clr = (state == ssdc_pkg::SSDC_SWITCH)
                       || (state == ssdc_pkg::SSDC_CONVERT && conv_end);   // [RULE14]

    ssdc_unit_timer u_unit_timer (
        .clk   (clk),
        .rst_n (rst_n),
        .clr   (timer_clr),
        .tick  (unit_tick)                                                 // [RULE3]
    );

    always_comb begin
        next_state = state;
        unique case (state)
            ssdc_pkg::SSDC_IDLE: begin
                if (cfg_auto ? run_level : pulse_evt) begin                // [RULE6]
                    next_state = ssdc_pkg::SSDC_SWITCH;
                end
            end
            ssdc_pkg::SSDC_SWITCH: begin
                next_state = ssdc_pkg::SSDC_SETTLE;
            end
            ssdc_pkg::SSDC_SETTLE: begin
                if (settled) begin                                         // [RULE1] [RULE4]
                    next_state = ssdc_pkg::SSDC_CONVERT;
                end
            end
            ssdc_pkg::SSDC_CONVERT: begin
                if (conv_end) begin
                    // chop reverses polarity and settles again before phase two
                    next_state = (cfg_chop && !phase) ? ssdc_pkg::SSDC_SETTLE
                                                      : ssdc_pkg::SSDC_DONE; // [RULE5] [RULE7]
                end
            end
            ssdc_pkg::SSDC_DONE: begin
                // pulse mode stops after one channel; auto runs while started
                next_state = (cfg_auto && run_level) ? ssdc_pkg::SSDC_SWITCH
                                                     : ssdc_pkg::SSDC_IDLE; // [RULE6]
            end
            default: begin
                next_state = ssdc_pkg::SSDC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ssdc_pkg::SSDC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // settle unit counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            unit_cnt <= 6'h00;
        end else if (timer_clr) begin
            unit_cnt <= 6'h00;                                             // [RULE14]
        end else if (state == ssdc_pkg::SSDC_SETTLE && !settled && unit_tick) begin
            unit_cnt <= unit_cnt + 6'h01;                                  // [RULE1]
        end
    end

    // conversion length counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_cnt <= 14'h0000;
        end else if (state != ssdc_pkg::SSDC_CONVERT || conv_end) begin
            conv_cnt <= 14'h0000;
        end else begin
            conv_cnt <= conv_cnt + 14'h0001;                               // [RULE12]
        end
    end

    // channel pair and chop phase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pair  <= 3'h0;
            phase <= 1'b0;
        end else begin
            if (state == ssdc_pkg::SSDC_SWITCH) begin
                phase <= 1'b0;
            end else if (state == ssdc_pkg::SSDC_CONVERT && conv_end && cfg_chop) begin
                phase <= 1'b1;                                             // [RULE5]
            end
            // the finished pair advances so a later start picks up the next one
            if (state == ssdc_pkg::SSDC_DONE) begin
                pair <= next_pair(pair, chan_mask);
            end
        end
    end

    // ==========================================
    // outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mux_pos_sel   <= 4'h0;
            mux_neg_sel   <= 4'h1;
            mux_out_en    <= 1'b0;
            loop_internal <= 1'b1;
            chop_reverse  <= 1'b0;
            conv_avg      <= 7'h40;
        end else begin
            mux_pos_sel   <= {pair, 1'b0};
            mux_neg_sel   <= {pair, 1'b1};
            mux_out_en    <= 1'b1;                                         // [RULE9]
            loop_internal <= !main_config_reg[`SSDC_BIT_BYPASS];           // [RULE8]
            chop_reverse  <= phase;                                        // [RULE5]
            conv_avg      <= avg_count(rate_sel);                          // [RULE13]
        end
    end

    // bias follows the selected pair only; others see no current
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bias_src_en  <= 16'h0000;
            bias_sink_en <= 16'h0000;
            bias_high    <= 1'b0;
        end else begin
            bias_high <= main_config_reg[`SSDC_BIT_BIAS_HIGH];             // [RULE10]
            if (main_config_reg[`SSDC_BIT_BIAS_EN] && state != ssdc_pkg::SSDC_IDLE) begin
                bias_src_en  <= 16'h0001 << {pair, 1'b0};                  // [RULE10] [RULE11]
                bias_sink_en <= 16'h0002 << {pair, 1'b0};                  // [RULE10] [RULE11]
            end else begin
                bias_src_en  <= 16'h0000;
                bias_sink_en <= 16'h0000;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_start   <= 1'b0;
            data_ready   <= 1'b0;
            result_count <= 8'h00;
        end else begin
            conv_start <= (state == ssdc_pkg::SSDC_SETTLE) && settled;     // [RULE1]
            data_ready <= (state == ssdc_pkg::SSDC_DONE);                  // [RULE5] [RULE6]
            if (state == ssdc_pkg::SSDC_DONE) begin
                result_count <= result_count + 8'h01;
            end
        end
    end

    // ==========================================
    // read port
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `SSDC_OFS_MAIN_CONFIG:  reg_rdata <= main_config_reg;
                `SSDC_OFS_TIMING:       reg_rdata <= timing_reg;
                `SSDC_OFS_CHAN_MASK:    reg_rdata <= chan_mask;
                `SSDC_OFS_STATUS:       reg_rdata <= {state, phase, 1'b0, pair};
                `SSDC_OFS_RESULT_COUNT: reg_rdata <= result_count;
                default:                reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule : ssdc_scan_ctrl

// file: ssdc_scan_ctrl_monitor.sv
// concurrent checks on the scan controller's output ports
// assumes a bind onto ssdc_scan_ctrl; off while rstn is low
`timescale 1ns/1ps

module ssdc_scan_ctrl_monitor (
    // clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    // observed outputs
    input wire logic [3:0]  mux_pos_sel,
    input wire logic [3:0]  mux_neg_sel,
    input wire logic        mux_out_en,
    input wire logic [15:0] bias_src_en,
    input wire logic [15:0] bias_sink_en,
    input wire logic        conv_start,
    input wire logic [6:0]  conv_avg,
    input wire logic        data_ready
);
    // ==========================================
    // helper counters
    // reset sync eats two edges, so give the pins settling room
    logic [2:0]  up_cnt;
    logic [13:0] since_conv;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) up_cnt <= 3'h0;
        else if (up_cnt != 3'h7) up_cnt <= up_cnt + 3'h1;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) since_conv <= 14'h0;
        else if (conv_start) since_conv <= 14'h1;
        else if (since_conv != 14'h3fff) since_conv <= since_conv + 14'h1;
    end

    // ==========================================
    // properties
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    a_mux_driven: assert property (up_cnt == 3'h7 |-> mux_out_en)
        else $error("mux idle");
    a_src_selected: assert property (conv_start && bias_src_en != 16'h0
        |-> bias_src_en == (16'h1 << mux_pos_sel)) else $error("bias src");
    a_sink_selected: assert property (conv_start && bias_sink_en != 16'h0
        |-> bias_sink_en == (16'h1 << mux_neg_sel)) else $error("bias sink");
    a_bias_paired: assert property (conv_start
        |-> ((bias_src_en == 16'h0) == (bias_sink_en == 16'h0))) else $error("bias pair");
    a_neg_of_pair: assert property (conv_start
        |-> (!mux_pos_sel[0] && mux_neg_sel == {mux_pos_sel[3:1], 1'b1}))
        else $error("neg pair");
    a_conv_busy: assert property (conv_start |=> (!conv_start && !data_ready) [*8])
        else $error("short conv");
    a_ready_pulse: assert property (data_ready |=> !data_ready)
        else $error("long ready");
    a_avg_legal: assert property (conv_start
        |-> conv_avg inside {7'h01, 7'h04, 7'h10, 7'h40}) else $error("bad avg");
    a_conv_length: assert property (data_ready
        |-> (since_conv >= 14'd546 + ({7'h0, conv_avg} << 7)
             && since_conv <= 14'd549 + ({7'h0, conv_avg} << 7)))
        else $error("conv length");
    // selection outputs follow the pair one cycle after the result pulse
    a_sel_holds: assert property ($changed(mux_pos_sel) |-> $past(data_ready))
        else $error("sel moved");
endmodule : ssdc_scan_ctrl_monitor

bind ssdc_scan_ctrl ssdc_scan_ctrl_monitor u_mon (.clk, .rstn, .mux_pos_sel, .mux_neg_sel,
    .mux_out_en, .bias_src_en, .bias_sink_en, .conv_start, .conv_avg, .data_ready);

// file: ssdc_host_model.sv
// host controller model: register port master and start pin driver
// assumes the bench calls its tasks just after a rising edge of clk
`timescale 1ns/1ps

module ssdc_host_model (
    // clock
    input  wire logic       clk,
    // register port
    output logic      [2:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata,
    // conversion control pin
    output logic            start_pin
);
    initial begin
        reg_addr  = 3'h0;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        start_pin = 1'b0;
    end

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
        // stale data would hide a late sample
        reg_wdata <= ~d;
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask : rd

    // delay stays programmed under chop so the reversed phase settles
    task automatic setup(input logic [2:0] dly, input logic [1:0] rate, input logic [7:0] main);
        wr(3'h1, {2'b00, rate, 1'b0, dly});
        wr(3'h0, main);
    endtask : setup

    // pulse pacing is left to the caller, one level change per call
    task automatic pin(input logic v);
        @(posedge clk);
        start_pin <= v;
    endtask : pin
endmodule : ssdc_host_model

// file: scan_switch_delay_control_bench.sv
// self-checking bench for the scan controller
// assumes the monitor is bound onto the design by its own file
`timescale 1ns/1ps

module scan_switch_delay_control_bench;
    // ==========================================
    // signals
    logic        clk;
    logic        rstn;
    logic [2:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic        start_pin;
    logic [3:0]  mux_pos_sel;
    logic [3:0]  mux_neg_sel;
    logic        mux_out_en;
    logic        loop_internal;
    logic        chop_reverse;
    logic [15:0] bias_src_en;
    logic [15:0] bias_sink_en;
    logic        bias_high;
    logic        conv_start;
    logic [6:0]  conv_avg;
    logic        data_ready;
    int          errors;
    int          n_checks;
    int          pair;
    int          n_res;
    int          n;
    logic [31:0] seed;
    logic [7:0]  main_cfg;
    logic [7:0]  mask;
    logic [7:0]  rv;
    logic [7:0]  rst_tbl [8] = '{8'h10, 8'h30, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    ssdc_scan_ctrl u_dut (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .start_pin, .mux_pos_sel, .mux_neg_sel, .mux_out_en, .loop_internal, .chop_reverse,
        .bias_src_en, .bias_sink_en, .bias_high, .conv_start, .conv_avg, .data_ready);

    ssdc_host_model u_host (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .start_pin);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ==========================================
    // expectations and helpers
    function automatic logic [31:0] xorshift(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction : xorshift

    function automatic int units_of(input int d);
        int tbl [8] = '{0, 1, 2, 4, 8, 16, 32, 48};
        return tbl[d];
    endfunction : units_of

    function automatic int avg_of(input int r);
        return 1 << (2 * (3 - r));
    endfunction : avg_of

    function automatic int nxt(input int p);
        for (int k = 1; k <= 8; k++) begin
            if (mask[(p + k) % 8]) return (p + k) % 8;
        end
        return p;
    endfunction : nxt

    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : test_done

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t saw %h want %h", $time, seen, exp);
        end
    endtask : check

    // bounded wait, sampled mid-cycle; after a result the pair outputs lag one cycle
    task automatic wait_sig(input bit rdy, output int cnt);
        cnt = 0;
        do begin
            @(negedge clk);
            cnt++;
        end while ((rdy ? data_ready : conv_start) !== 1'b1 && cnt < 20000);
        if (rdy) @(negedge clk);
        if (cnt >= 20000) begin
            errors++;
            $display("[ERR] %0t wait ran out", $time);
            test_done();
        end
    endtask : wait_sig

    task automatic quiet(input int cycles);
        int hits;
        hits = 0;
        repeat (cycles) begin
            @(posedge clk);
            if (conv_start !== 1'b0 || data_ready !== 1'b0) hits++;
        end
        check(32'(hits), 32'h0);
    endtask : quiet

    task automatic look();
        check(32'(mux_out_en), 32'h1);
        check(32'(loop_internal), 32'(!main_cfg[0]));
        check(32'(bias_high), 32'(main_cfg[3]));
        check(32'(mux_neg_sel), 32'(2 * pair + 1));
        check(32'(bias_src_en), main_cfg[2] ? 32'h1 << (2 * pair) : 32'h0);
        check(32'(bias_sink_en), main_cfg[2] ? 32'h2 << (2 * pair) : 32'h0);
    endtask : look

    // one channel; lat allows for pin sync
    task automatic convert_one(input int d, input int r, input int lat);
        int dl;
        int cl;
        dl = 128 * units_of(d);
        cl = 546 + 128 * avg_of(r);
        wait_sig(1'b0, n);
        check(32'(n >= dl + 2 && n <= dl + 7 + lat), 32'h1);
        check(32'(conv_avg), 32'(avg_of(r)));
        look();
        if (main_cfg[1]) begin
            wait_sig(1'b0, n);
            check(32'(n >= cl + dl && n <= cl + dl + 5), 32'h1);
            check(32'(chop_reverse), 32'h1);
        end
        wait_sig(1'b1, n);
        check(32'(n >= cl && n <= cl + 3), 32'h1);
        pair = nxt(pair);
        n_res++;
        check(32'(mux_pos_sel), 32'(2 * pair));
    endtask : convert_one

    // ==========================================
    // main sequence
    initial begin
        errors = 0;
        n_checks = 0;
        pair = 0;
        n_res = 0;
        seed = 32'hf9e5;
        mask = 8'hff;
        main_cfg = 8'h10;
        rstn = 1'b0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (5) @(posedge clk);
        for (int a = 0; a < 8; a++) begin
            u_host.rd(3'(a), rv);
            check(32'(rv), 32'(rst_tbl[a]));
        end
        u_host.wr(3'h1, 8'hff);
        u_host.rd(3'h1, rv);
        check(32'(rv), 32'h37);
        $display("test registers done");
        for (int d = 0; d < 8; d++) begin
            seed = xorshift(seed);
            main_cfg = {4'h0, seed[3:2], 1'b0, seed[0]};
            u_host.setup(3'(d), 2'h3, main_cfg);
            u_host.wr(3'h3, 8'h01);
            convert_one(d, 3, 0);
        end
        $display("test delay codes done");
        for (int r = 0; r < 4; r++) begin
            seed = xorshift(seed);
            main_cfg = {4'h0, seed[5:4], seed[1], seed[6]};
            u_host.setup(3'h0, 2'(r), main_cfg);
            u_host.wr(3'h3, 8'h01);
            convert_one(0, r, 0);
        end
        $display("test rates done");
        seed = xorshift(seed);
        main_cfg = {4'h0, seed[3:2], 1'b0, seed[0]};
        u_host.setup(3'h2, 2'h2, main_cfg);
        u_host.pin(1'b1);
        convert_one(2, 2, 6);
        u_host.pin(1'b0);
        u_host.wr(3'h3, 8'h01);
        wait_sig(1'b0, n);
        u_host.wr(3'h3, 8'h01);
        u_host.pin(1'b1);
        wait_sig(1'b1, n);
        pair = nxt(pair);
        n_res++;
        quiet(1500);
        u_host.pin(1'b0);
        u_host.rd(3'h4, rv);
        check(32'(rv), 32'(pair));
        $display("test pulse events done");
        seed = xorshift(seed);
        mask = seed[7:0] | (8'h01 << pair);
        main_cfg = {4'h3, seed[11:10], 1'b0, seed[8]};
        u_host.wr(3'h2, mask);
        u_host.setup(3'h1, 2'h3, main_cfg);
        for (int k = 0; k < 5; k++) begin
            if (k == 4) u_host.wr(3'h0, main_cfg & 8'hdf);
            wait_sig(1'b1, n);
            if (k > 0 && k < 4) check(32'(n >= 802 && n <= 810), 32'h1);
            pair = nxt(pair);
            n_res++;
            check(32'(mux_pos_sel), 32'(2 * pair));
        end
        quiet(1200);
        u_host.rd(3'h5, rv);
        check(32'(rv), 32'(n_res % 256));
        $display("test auto scan done");
        test_done();
    end
endmodule : scan_switch_delay_control_bench
